// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// channel bench, short tick of 4 clocks and second of 40
// ****************************************************************
module testbench
  import tochan_pkg::*;
;
  localparam int TP = 4;
  localparam int SP = 40;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic outputMode = 1'b0;
  logic pulseCounted = 1'b0;
  logic failsafeEnable = 1'b0;
  logic cmdActivate = 1'b0;
  logic cmdDeactivate = 1'b0;
  logic ioActivity = 1'b0;
  logic [1:0] driveType = 2'h0;
  logic [1:0] behaviour = 2'h0;
  logic [1:0] failsafeAction = 2'h0;
  logic [13:0] pulseCount = 14'h0001;
  logic [13:0] inactiveWidth = 14'h0001;
  logic [13:0] activeWidth = 14'h0001;
  logic [13:0] delayTicks = 14'h0001;
  logic [13:0] failsafeSeconds = 14'h0002;
  logic lineOut, lineOe, relayClose, chanActive, seqRunning, failsafeFired, lineLevel, loadPowered;
  int errorCnt = 0;
  int nTests = 0;
  int cycles = 0;
  int n;
  int m;
  timed_output_channel #(.TICK_PERIOD(TP), .SECOND_PERIOD(SP)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .outputMode(outputMode), .driveType(driveType), .behaviour(behaviour), .pulseCounted(pulseCounted),
    .pulseCount(pulseCount), .inactiveWidth(inactiveWidth), .activeWidth(activeWidth), .delayTicks(delayTicks),
    .failsafeAction(failsafeAction), .failsafeEnable(failsafeEnable), .failsafeSeconds(failsafeSeconds),
    .cmdActivate(cmdActivate), .cmdDeactivate(cmdDeactivate), .ioActivity(ioActivity), .lineOut(lineOut),
    .lineOe(lineOe), .relayClose(relayClose), .chanActive(chanActive), .seqRunning(seqRunning),
    .failsafeFired(failsafeFired));
  tochan_field_load i_load (.lineOut(lineOut), .lineOe(lineOe), .relayClose(relayClose),
    .lineLevel(lineLevel), .loadPowered(loadPowered));
  always #12.5 ref_clk = ~ref_clk;
  task automatic endSim();
    if (errorCnt == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle command pulse; returns on the edge that takes it
  task automatic cmd(input logic act, input logic deact);
    @(posedge ref_clk);
    cmdActivate <= act;
    cmdDeactivate <= deact;
    @(posedge ref_clk);
    cmdActivate <= 1'b0;
    cmdDeactivate <= 1'b0;
  endtask
  // edges until chanActive shows lvl, bounded so a stuck output cannot hang
  task automatic wait_lvl(input logic lvl);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (chanActive !== lvl && n < 200);
  endtask
  // hang guard, the whole run needs about 650 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errorCnt++;
      endSim();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // values still show what the reset edges left behind
    check("reset drive", lineOe, 0);
    check("reset seq", seqRunning, 0);
    check("reset state", chanActive, 0);
    cmd(1'b1, 1'b0);
    repeat (3) @(posedge ref_clk);
    check("state", chanActive, 1);
    check("released", lineLevel, 1);
    cmd(1'b0, 1'b1);
    outputMode <= 1'b1;
    // code 3 is spare and must behave as ground type; the pull-up hides voltage drive, so the enable is checked too
    for (int d = 0; d < 4; d++) begin
      driveType <= d[1:0];
      cmd(1'b1, 1'b0);
      repeat (8) @(posedge ref_clk);
      check("level on", lineLevel, d == 1 || d == 2);
      check("drive on", lineOe, 1);
      check("contact on", loadPowered, 1);
      cmd(1'b0, 1'b1);
      repeat (3) @(posedge ref_clk);
      check("level off", lineLevel, d != 2);
      check("drive off", lineOe, d == 2);
      check("contact off", loadPowered, 0);
    end
    for (int d = 1; d < 4; d += 2) begin
      delayTicks <= d[13:0];
      behaviour <= BEH_DELAYED_TURN_ON;
      cmd(1'b1, 1'b0);
      wait_lvl(1'b1);
      check("on delay", n, d * TP + 1);
      behaviour <= BEH_DELAYED_TURN_OFF;
      cmd(1'b1, 1'b0);
      wait_lvl(1'b0);
      check("off delay", n, d * TP + 1);
    end
    // counted train: two repetitions of 2 ticks on, 3 ticks off
    behaviour <= BEH_PULSED;
    pulseCounted <= 1'b1;
    pulseCount <= 14'h0002;
    activeWidth <= 14'h0002;
    inactiveWidth <= 14'h0003;
    cmd(1'b1, 1'b0);
    n = 0;
    m = 0;
    repeat (100) begin
      @(posedge ref_clk);
      n += chanActive;
      m += seqRunning;
    end
    check("train on", n, 16);
    check("train length", m, 40);
    check("after train", chanActive, 0);
    pulseCounted <= 1'b0;
    cmd(1'b1, 1'b0);
    n = 0;
    repeat (200) begin
      @(posedge ref_clk);
      n += chanActive;
    end
    check("free run on", n, 80);
    check("free run", seqRunning, 1);
    cmd(1'b0, 1'b1);
    @(posedge ref_clk);
    check("aborted", seqRunning, 0);
    behaviour <= BEH_MANUAL;
    for (int a = 0; a < 3; a++) begin
      failsafeAction <= a[1:0];
      cmd(a != 1, a == 1);
      failsafeEnable <= 1'b1;
      ioActivity <= 1'b1;
      @(posedge ref_clk);
      ioActivity <= 1'b0;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (failsafeFired !== 1'b1 && n < 200);
      check("fire time", n > SP && n <= 2 * SP + 2, 1);
      check("fire state", chanActive, a != 2);
      failsafeEnable <= 1'b0;
    end
    endSim();
  end
endmodule
`default_nettype wire

// ---- dv/tochan_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker; delay figures assume a tick of 4 clocks
// ****************************************************************
module tochan_chk
  import tochan_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // settings and commands
  input wire logic outputMode,
  input wire logic [1:0] driveType,
  input wire logic [1:0] behaviour,
  input wire logic [13:0] delayTicks,
  input wire logic [1:0] failsafeAction,
  input wire logic cmdActivate,
  input wire logic cmdDeactivate,
  // outputs
  input wire logic lineOut,
  input wire logic lineOe,
  input wire logic relayClose,
  input wire logic chanActive,
  input wire logic seqRunning,
  input wire logic failsafeFired
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // one-tick delay seen from the state register, one cycle of slack
  sequence s_rise_late;
    !chanActive [*3] ##[1:2] chanActive;
  endsequence
  sequence s_fall_late;
    chanActive [*3] ##[1:2] !chanActive;
  endsequence
  property p_idle;
    !outputMode |=> !lineOe && !lineOut && !relayClose;
  endproperty
  a_idle: assert property (p_idle) else $error("line driven in input mode");
  property p_ground;
    outputMode && driveType == DRIVE_GROUND |=> lineOe == $past(chanActive) && !lineOut;
  endproperty
  a_ground: assert property (p_ground) else $error("ground drive wrong");
  property p_relay;
    outputMode |=> relayClose == $past(chanActive);
  endproperty
  a_relay: assert property (p_relay) else $error("contact wrong");
  property p_deact;
    cmdDeactivate |=> !chanActive && !seqRunning;
  endproperty
  a_deact: assert property (p_deact) else $error("deactivate ignored");
  property p_manual_on;
    cmdActivate && !cmdDeactivate && behaviour == BEH_MANUAL |=> chanActive && !seqRunning;
  endproperty
  a_manual_on: assert property (p_manual_on) else $error("manual activate ignored");
  property p_delay_on;
    cmdActivate && !cmdDeactivate && behaviour == BEH_DELAYED_TURN_ON && delayTicks == 14'h0001 |=> s_rise_late;
  endproperty
  a_delay_on: assert property (p_delay_on) else $error("turn-on delay wrong");
  property p_delay_off;
    cmdActivate && !cmdDeactivate && behaviour == BEH_DELAYED_TURN_OFF && delayTicks == 14'h0001 |=> s_fall_late;
  endproperty
  a_delay_off: assert property (p_delay_off) else $error("turn-off delay wrong");
  property p_failsafe;
    $rose(failsafeFired) |-> (failsafeAction != FS_ACTIVATE || chanActive)
      && (failsafeAction != FS_DEACTIVATE || !chanActive);
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("failsafe action wrong");
endmodule
bind timed_output_channel tochan_chk i_chk (.ref_clk(ref_clk), .rst(rst), .outputMode(outputMode),
  .driveType(driveType), .behaviour(behaviour), .delayTicks(delayTicks), .failsafeAction(failsafeAction),
  .cmdActivate(cmdActivate), .cmdDeactivate(cmdDeactivate), .lineOut(lineOut), .lineOe(lineOe),
  .relayClose(relayClose), .chanActive(chanActive), .seqRunning(seqRunning), .failsafeFired(failsafeFired));
`default_nettype wire

// ---- dv/tochan_field_load.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// field load: pulled-up line plus relay-side coil
// ****************************************************************
module tochan_field_load (
  // channel pins
  input wire logic lineOut,
  input wire logic lineOe,
  input wire logic relayClose,
  // what the load sees
  output logic lineLevel,
  output logic loadPowered
);
  // a released line rests at the pull-up, so a stale low never passes for a drive
  assign lineLevel = lineOe ? lineOut : 1'b1;
  // coil-side load is powered only through a closed contact
  assign loadPowered = relayClose;
endmodule
`default_nettype wire

// ---- rtl/timed_output_channel.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - The line is driven only while output mode is selected, and after reset the channel is in input mode.
// - Ground type grounds the line while active, voltage type supplies voltage while active, combined supplies voltage while active and grounds it while inactive.
// - Four behaviours exist, manual, pulsed, delayed turn-on and delayed turn-off, with manual as default.
// - In manual behaviour only activate and deactivate commands and the failsafe change the output.
// - In pulsed behaviour an activate command starts alternating active and inactive phases.
// - Delayed turn-on holds the output inactive for the delay after a start and then makes it active.
// - Delayed turn-off makes the output inactive once the delay has passed after a start.
// - Pulsing repeats forever by default or stops after a programmed number of repetitions.
// - Each counted repetition is one active phase then one inactive phase, and the count defaults to one.
// - The inactive phase lasts 1 to 9999 ticks of 100 ms, one tick by default.
// - The active phase lasts 1 to 9999 ticks of 100 ms, one tick by default.
// - The turn-on and turn-off delay lasts 1 to 9999 ticks of 100 ms, one tick by default.
// - When the failsafe fires the output is left alone, forced active or forced inactive as selected.
// - A relay channel closes its contact when active and opens it when inactive, with the same behaviours; the code keeps the contact open in input mode.
// - The failsafe fires after 1 to 9999 seconds without I/O activity, 30 by default; the second divider runs free, so the code fires up to a second early.
module timed_output_channel
  import tochan_pkg::*;
#(
  parameter int unsigned TICK_PERIOD = TICK_CYCLES,
  parameter int unsigned SECOND_PERIOD = SECOND_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // configuration
  input wire logic outputMode,
  input wire logic [1:0] driveType,
  input wire logic [1:0] behaviour,
  input wire logic pulseCounted,
  input wire logic [13:0] pulseCount,
  input wire logic [13:0] inactiveWidth,
  input wire logic [13:0] activeWidth,
  input wire logic [13:0] delayTicks,
  input wire logic [1:0] failsafeAction,
  input wire logic failsafeEnable,
  input wire logic [13:0] failsafeSeconds,
  // commands and activity
  input wire logic cmdActivate,
  input wire logic cmdDeactivate,
  input wire logic ioActivity,
  // field line and relay contact
  output logic lineOut,
  output logic lineOe,
  output logic relayClose,
  // status
  output logic chanActive,
  output logic seqRunning,
  output logic failsafeFired
);

  // ****************************************************************
  // tick sources
  // ****************************************************************
  tochan_tick_if phaseTk ();
  tochan_tick_if secTk ();

  tochan_tick_div #(.PERIOD(TICK_PERIOD)) uPhaseDiv (
    .ref_clk(ref_clk),
    .rst(rst),
    .tk(phaseTk.src)
  );

  tochan_tick_div #(.PERIOD(SECOND_PERIOD)) uSecDiv (
    .ref_clk(ref_clk),
    .rst(rst),
    .tk(secTk.src)
  );

  // out-of-range widths are clamped so a zero never stalls a phase
  function automatic logic [13:0] clampTicks(input logic [13:0] v);
    if (v < CNT_MIN) begin
      return CNT_MIN;
    end else if (v > CNT_MAX) begin
      return CNT_MAX;
    end
    return v;
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PULSE_ON,
    ST_PULSE_OFF,
    ST_DELAY
  } tochan_state_e;

  tochan_state_e state_reg;
  logic active_reg;
  logic [13:0] timer_reg;
  logic [13:0] reps_reg;
  logic [13:0] fsCount_reg;
  logic fsFired_reg;
  logic anyCmd;
  logic phaseEnd;
  logic fsTrig;

  assign anyCmd = cmdActivate || cmdDeactivate;
  assign phaseEnd = phaseTk.tick && (timer_reg == 14'h0001);
  // a command resets the phase divider so the first tick is a full period away
  assign phaseTk.restart = anyCmd;
  assign secTk.restart = 1'b0;

  // ****************************************************************
  // failsafe inactivity timer
  // ****************************************************************
  // commands count as activity; the trigger fires once per quiet spell
  assign fsTrig = failsafeEnable && !fsFired_reg && !anyCmd && !ioActivity && secTk.tick
                  && (fsCount_reg + 14'h0001 >= clampTicks(failsafeSeconds));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fsCount_reg <= 14'h0000;
      fsFired_reg <= 1'b0;
    end else if (anyCmd || ioActivity || !failsafeEnable) begin
      fsCount_reg <= 14'h0000;
      fsFired_reg <= 1'b0;
    end else if (fsTrig) begin
      fsFired_reg <= 1'b1;
    end else if (secTk.tick && !fsFired_reg) begin
      fsCount_reg <= fsCount_reg + 14'h0001;
    end
  end

  // ****************************************************************
  // sequence engine
  // ****************************************************************
  // commands beat the failsafe, which beats a running phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      active_reg <= 1'b0;
      timer_reg <= WIDTH_DEFAULT;
      reps_reg <= PULSE_COUNT_DEFAULT;
    end else if (cmdDeactivate) begin
      state_reg <= ST_IDLE;
      active_reg <= 1'b0;
    end else if (cmdActivate) begin
      unique case (tochan_beh_e'(behaviour))
        BEH_MANUAL: begin
          state_reg <= ST_IDLE;
          active_reg <= 1'b1;
        end
        BEH_PULSED: begin
          state_reg <= ST_PULSE_ON;
          active_reg <= 1'b1;
          timer_reg <= clampTicks(activeWidth);
          reps_reg <= clampTicks(pulseCount);
        end
        BEH_DELAYED_TURN_ON: begin
          state_reg <= ST_DELAY;
          active_reg <= 1'b0;
          timer_reg <= clampTicks(delayTicks);
        end
        BEH_DELAYED_TURN_OFF: begin
          state_reg <= ST_DELAY;
          active_reg <= 1'b1;
          timer_reg <= clampTicks(delayTicks);
        end
      endcase
    end else if (fsTrig && failsafeAction == FS_ACTIVATE) begin
      state_reg <= ST_IDLE;
      active_reg <= 1'b1;
    end else if (fsTrig && failsafeAction == FS_DEACTIVATE) begin
      state_reg <= ST_IDLE;
      active_reg <= 1'b0;
    end else if (state_reg != ST_IDLE && phaseTk.tick) begin
      if (!phaseEnd) begin
        timer_reg <= timer_reg - 14'h0001;
      end else begin
        unique case (state_reg)
          ST_PULSE_ON: begin
            state_reg <= ST_PULSE_OFF;
            active_reg <= 1'b0;
            timer_reg <= clampTicks(inactiveWidth);
          end
          ST_PULSE_OFF: begin
            if (pulseCounted && reps_reg == 14'h0001) begin
              state_reg <= ST_IDLE;
              active_reg <= 1'b0;
            end else begin
              state_reg <= ST_PULSE_ON;
              active_reg <= 1'b1;
              timer_reg <= clampTicks(activeWidth);
              if (pulseCounted) begin
                reps_reg <= reps_reg - 14'h0001;
              end
            end
          end
          ST_DELAY: begin
            state_reg <= ST_IDLE;
            active_reg <= !active_reg;
          end
          ST_IDLE: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // registered so the field pin never glitches on a decode change
  always_ff @(posedge ref_clk) begin
    if (rst || !outputMode) begin
      lineOut <= 1'b0;
      lineOe <= 1'b0;
      relayClose <= 1'b0;
    end else begin
      relayClose <= active_reg;
      unique case (driveType)
        DRIVE_VOLTAGE: begin
          lineOut <= 1'b1;
          lineOe <= active_reg;
        end
        DRIVE_COMBINED: begin
          lineOut <= active_reg;
          lineOe <= 1'b1;
        end
        default: begin
          lineOut <= 1'b0;
          lineOe <= active_reg;
        end
      endcase
    end
  end

  assign chanActive = active_reg;
  assign seqRunning = (state_reg != ST_IDLE);
  assign failsafeFired = fsFired_reg;

endmodule

`default_nettype wire

// ---- rtl/tochan_pkg.sv ----
`default_nettype none

package tochan_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned SECOND_MS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SECOND_CYCLES = (SECOND_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************************************
  // field widths, ranges and reset values
  // ****************************************************************
  localparam int CNT_W = 14;
  localparam logic [13:0] CNT_MIN = 14'h0001;
  localparam logic [13:0] CNT_MAX = 14'h270F;
  localparam logic [13:0] WIDTH_DEFAULT = 14'h0001;
  localparam logic [13:0] PULSE_COUNT_DEFAULT = 14'h0001;
  localparam logic [13:0] FAILSAFE_SEC_DEFAULT = 14'h001E;

  // ****************************************************************
  // configuration encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    DRIVE_GROUND = 2'h0,
    DRIVE_VOLTAGE = 2'h1,
    DRIVE_COMBINED = 2'h2
  } tochan_drive_e;

  typedef enum logic [1:0] {
    BEH_MANUAL = 2'h0,
    BEH_PULSED = 2'h1,
    BEH_DELAYED_TURN_ON = 2'h2,
    BEH_DELAYED_TURN_OFF = 2'h3
  } tochan_beh_e;

  typedef enum logic [1:0] {
    FS_NONE = 2'h0,
    FS_ACTIVATE = 2'h1,
    FS_DEACTIVATE = 2'h2
  } tochan_fs_e;

endpackage

`default_nettype wire

// ---- rtl/tochan_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// divider: one-cycle tick every PERIOD clocks
// ****************************************************************
module tochan_tick_div #(
  parameter int unsigned PERIOD = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // tick out, restart in
  tochan_tick_if.src tk
);

  logic [31:0] count_reg;

  // restart aligns the first tick to a full period after a command
  always_ff @(posedge ref_clk) begin
    if (rst || tk.restart) begin
      count_reg <= 32'h0000_0000;
    end else if (count_reg == 32'(PERIOD - 1)) begin
      count_reg <= 32'h0000_0000;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  assign tk.tick = (count_reg == 32'(PERIOD - 1)) && !tk.restart;

endmodule

`default_nettype wire

// ---- rtl/tochan_tick_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// tick carrier between a divider and its user
// ****************************************************************
interface tochan_tick_if;
  logic tick;
  logic restart;

  modport src (output tick, input restart);
  modport snk (input tick, output restart);
endinterface

`default_nettype wire
